// ===== hw/rsap_axis.v
// homing state machine and axis parameter logic of a stepper axis
`timescale 1ns/10ps
`include "rsap_regs.vh"

// What this block does
// [RULE1] mode 1: seek left stop switch only
// [RULE2] mode 2: right stop, then left stop
// [RULE3] mode 3: right stop, then left both sides
// [RULE4] mode 4: left stop from both sides
// [RULE5] mode 5: home negative, reverse at left stop
// [RULE6] mode 6: home positive, reverse at right stop
// [RULE7] mode 7: home positive, ignore end switches
// [RULE8] mode 8: home negative, ignore end switches
// [RULE9] plus 128 inverts home switch polarity
// [RULE10] plus 64 uses right switch instead of left
// [RULE11] coarse phase runs at coarse search speed
// [RULE12] switching point found at fine speed
// [RULE13] modes 2/3 record distance between end switches
// [RULE14] capture position before zeroing the counter
// [RULE15] boost current drives ramps, run scaling
// [RULE16] boost zero falls back to run current
// [RULE17] cut power after freewheel delay at standstill
// [RULE18] zero freewheel delay never cuts power
// [RULE19] load measurement readable, 0 to 1023
// [RULE20] error bit0 stall, bit1 deviation
// [RULE21] errors clear on read or motion command
// [RULE22] stop on excess encoder deviation, zero disables
// [RULE23] stop on zero load above stall speed
// [RULE24] coarse to switch, fine to edge, zero
module rsap_axis #(
    parameter TICK_CYC = `RSAP_TICK_NS / `RSAP_CLK_NS
) (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] par_num,
    input wire par_wr,
    input wire par_rd,
    input wire [31:0] par_wdata,
    input wire homing_command,
    input wire motion_cmd,
    input wire ext_step,
    input wire ext_dir,
    input wire [31:0] ext_vel,
    input wire ext_ramp,
    input wire [7:0] run_current,
    input wire [9:0] load_value,
    input wire [31:0] enc_pos,
    input wire stop_left,
    input wire stop_right,
    input wire home_sw,
    output reg [31:0] par_rdata_q,
    output reg par_ack_q,
    output reg [31:0] pos_q,
    output reg step_q,
    output reg dir_q,
    output reg homing_busy_q,
    output reg [7:0] coil_current_q,
    output reg power_en_q,
    output reg motor_stop_q
);

// -----------------------------------------------------------------
// constants and states
// -----------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_SEEK = 3'h1;
localparam [2:0] ST_EDGE = 3'h2;
localparam [2:0] ST_BACK = 3'h3;
localparam [2:0] ST_ZERO = 3'h4;
localparam [1:0] TG_LEFT = 2'h0;
localparam [1:0] TG_RIGHT = 2'h1;
localparam [1:0] TG_HOME = 2'h2;
localparam [31:0] CLK_HZ = `RSAP_CLK_HZ;

// -----------------------------------------------------------------
// pin synchronisers
// -----------------------------------------------------------------
reg [2:0] sl_q, sr_q, sh_q;
reg left_q, right_q, home_q;

// three stages, accept a change when stages two and three agree
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        sl_q <= 3'h0;
        sr_q <= 3'h0;
        sh_q <= 3'h0;
        left_q <= 1'b0;
        right_q <= 1'b0;
        home_q <= 1'b0;
    end else begin
        sl_q <= {sl_q[1:0], stop_left};
        sr_q <= {sr_q[1:0], stop_right};
        sh_q <= {sh_q[1:0], home_sw};
        if (sl_q[1] == sl_q[2]) left_q <= sl_q[2];
        if (sr_q[1] == sr_q[2]) right_q <= sr_q[2];
        if (sh_q[1] == sh_q[2]) home_q <= sh_q[2];
    end
end

// -----------------------------------------------------------------
// parameter registers
// -----------------------------------------------------------------
reg [7:0] mode_q;
reg [31:0] coarse_q, fine_q, span_q, prepos_q, stall_spd_q, max_dev_q;
reg [7:0] boost_q;
reg [15:0] fw_delay_q;
reg [1:0] err_q;

function [31:0] abs32;
    input [31:0] v;
    begin
        abs32 = v[31] ? (~v + 32'h0000_0001) : v;
    end
endfunction

wire [3:0] base_mode = mode_q[3:0];
wire inv_home = mode_q[`RSAP_INV_HOME_BIT];
wire use_right = mode_q[`RSAP_RIGHT_BIT];

// -----------------------------------------------------------------
// homing state machine
// -----------------------------------------------------------------
reg [2:0] st_q;
reg [1:0] tgt_q;
reg seek_dir_q; // 1 = positive
reg first_q; // first leg of a two-leg search
reg both_q; // approach target from both sides
reg reversed_q;
reg fine_q_sel;
reg [31:0] mark_q;
reg [31:0] acc_q;
reg hstep_d;
// [RULE9] home polarity flip
wire tgt_hit = (tgt_q == TG_HOME) ? (home_q ^ inv_home) :
    (tgt_q == TG_RIGHT) ? right_q : left_q;
wire [31:0] hspeed = fine_q_sel ? fine_q : coarse_q;
wire [32:0] acc_sum = {1'b0, acc_q} + {1'b0, hspeed};
wire acc_ovf = acc_sum >= {1'b0, CLK_HZ};
wire stop_any = motor_stop_q;
// [RULE10] swap left and right
wire [1:0] stop_tgt = use_right ? TG_RIGHT : TG_LEFT;
wire [1:0] stop_opp = use_right ? TG_LEFT : TG_RIGHT;

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        st_q <= ST_IDLE;
        tgt_q <= TG_LEFT;
        seek_dir_q <= 1'b0;
        first_q <= 1'b0;
        both_q <= 1'b0;
        reversed_q <= 1'b0;
        fine_q_sel <= 1'b0;
        mark_q <= 32'h0000_0000;
        acc_q <= 32'h0000_0000;
        homing_busy_q <= 1'b0;
        span_q <= 32'h0000_0000;
        prepos_q <= 32'h0000_0000;
    end else begin
        // step-rate accumulator, one step per overflow
        if (st_q != ST_IDLE && st_q != ST_ZERO) begin
            acc_q <= acc_ovf ? acc_sum[31:0] - CLK_HZ : acc_sum[31:0];
        end else begin
            acc_q <= 32'h0000_0000;
        end
        case (st_q)
            ST_IDLE: begin
                homing_busy_q <= 1'b0;
                fine_q_sel <= 1'b0;
                reversed_q <= 1'b0;
                if (homing_command && !stop_any) begin
                    homing_busy_q <= 1'b1;
                    st_q <= ST_SEEK;
                    first_q <= 1'b0;
                    both_q <= 1'b0;
                    tgt_q <= stop_tgt;
                    seek_dir_q <= use_right;
                    if (base_mode == 4'h2 || base_mode == 4'h3) begin
                        // [RULE2] opposite switch first
                        first_q <= 1'b1;
                        tgt_q <= stop_opp;
                        seek_dir_q <= ~use_right;
                        // [RULE3] second leg from both sides
                        both_q <= (base_mode == 4'h3);
                    end else if (base_mode == 4'h4) begin
                        // [RULE4] both sides approach
                        both_q <= 1'b1;
                    end else if (base_mode == 4'h5 || base_mode == 4'h8) begin
                        // [RULE5] [RULE8] home, negative
                        tgt_q <= TG_HOME;
                        seek_dir_q <= 1'b0;
                    end else if (base_mode == 4'h6 || base_mode == 4'h7) begin
                        // [RULE6] [RULE7] home, positive
                        tgt_q <= TG_HOME;
                        seek_dir_q <= 1'b1;
                    end
                    // [RULE1] mode 1 keeps the plain stop seek
                end
            end
            ST_SEEK: begin
                // [RULE11] coarse search speed
                fine_q_sel <= 1'b0;
                if (stop_any) begin
                    st_q <= ST_IDLE;
                end else if (tgt_hit) begin
                    // [RULE24] switch found, move to fine
                    st_q <= ST_EDGE;
                    fine_q_sel <= 1'b1;
                end else if (!reversed_q && ((base_mode == 4'h5 && left_q) ||
                        (base_mode == 4'h6 && right_q))) begin
                    // [RULE5] [RULE6] reverse at end stop
                    seek_dir_q <= ~seek_dir_q;
                    reversed_q <= 1'b1;
                end
            end
            ST_EDGE: begin
                // [RULE12] leave the switch at fine speed
                if (stop_any) begin
                    st_q <= ST_IDLE;
                end else if (!tgt_hit) begin
                    if (first_q) begin
                        // [RULE13] first end switch position
                        mark_q <= pos_q;
                        first_q <= 1'b0;
                        tgt_q <= stop_tgt;
                        seek_dir_q <= use_right;
                        st_q <= ST_SEEK;
                    end else if (both_q) begin
                        st_q <= ST_BACK;
                    end else begin
                        st_q <= ST_ZERO;
                    end
                end
            end
            ST_BACK: begin
                // [RULE12] approach again in the seek direction, still at fine speed
                if (stop_any) begin
                    st_q <= ST_IDLE;
                end else if (tgt_hit) begin
                    st_q <= ST_ZERO;
                end
            end
            default: begin
                // [RULE14] keep position before zeroing
                prepos_q <= pos_q;
                // [RULE13] span between end switches
                if (base_mode == 4'h2 || base_mode == 4'h3) begin
                    span_q <= mark_q - pos_q;
                end
                st_q <= ST_IDLE;
            end
        endcase
    end
end

// step and direction during homing; edge phase runs away from seek dir
wire hdir = (st_q == ST_EDGE) ? ~seek_dir_q : seek_dir_q;
always @* begin
    hstep_d = (st_q == ST_SEEK || st_q == ST_EDGE || st_q == ST_BACK) &&
        acc_ovf && !stop_any;
end

// -----------------------------------------------------------------
// position counter and step outputs
// -----------------------------------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        pos_q <= 32'h0000_0000;
        step_q <= 1'b0;
        dir_q <= 1'b0;
    end else begin
        step_q <= homing_busy_q ? hstep_d : (ext_step && !stop_any);
        dir_q <= homing_busy_q ? hdir : ext_dir;
        if (st_q == ST_ZERO) begin
            // [RULE24] zero at the switching point
            pos_q <= 32'h0000_0000;
        end else if (homing_busy_q ? hstep_d : (ext_step && !stop_any)) begin
            if (homing_busy_q ? hdir : ext_dir) begin
                pos_q <= pos_q + 32'h0000_0001;
            end else begin
                pos_q <= pos_q - 32'h0000_0001;
            end
        end
    end
end

// -----------------------------------------------------------------
// error detection and motor stop
// -----------------------------------------------------------------
wire [31:0] cur_speed = homing_busy_q ? hspeed : abs32(ext_vel);
wire [31:0] dev = abs32(pos_q - enc_pos);
// [RULE23] stall above the stop speed
wire stall_ev = (cur_speed > stall_spd_q) && (load_value == 10'h000);
// [RULE22] deviation check, zero limit disables
wire dev_ev = (max_dev_q != 32'h0000_0000) && (dev > max_dev_q);
wire err_rd = par_rd && (par_num == `RSAP_ERR);

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        err_q <= 2'h0;
        motor_stop_q <= 1'b0;
    end else begin
        // [RULE21] clear on read or motion, new event wins
        if (err_rd || motion_cmd || homing_command) begin
            err_q <= {dev_ev, stall_ev};
        end else begin
            // [RULE20] stall bit0, deviation bit1
            err_q <= err_q | {dev_ev, stall_ev};
        end
        if (stall_ev || dev_ev) begin
            motor_stop_q <= 1'b1;
        end else if (motion_cmd || homing_command) begin
            motor_stop_q <= 1'b0;
        end
    end
end

// -----------------------------------------------------------------
// current selection and freewheeling
// -----------------------------------------------------------------
reg [31:0] tick_cnt_q;
reg [15:0] still_q;
wire moving = homing_busy_q || (ext_vel != 32'h0000_0000);
wire tick = (tick_cnt_q == TICK_CYC - 1);

always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        coil_current_q <= 8'h00;
        tick_cnt_q <= 32'h0000_0000;
        still_q <= 16'h0000;
        power_en_q <= 1'b1;
    end else begin
        // [RULE15] boost during ramps
        if (ext_ramp && boost_q != 8'h00) begin
            coil_current_q <= boost_q;
        end else begin
            // [RULE16] run current when boost is zero
            coil_current_q <= run_current;
        end
        tick_cnt_q <= (moving || tick) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        if (moving) begin
            still_q <= 16'h0000;
            power_en_q <= 1'b1;
        end else if (fw_delay_q == 16'h0000) begin
            // [RULE18] zero delay keeps power on
            power_en_q <= 1'b1;
        end else if (still_q >= fw_delay_q) begin
            // [RULE17] cut power after the delay
            power_en_q <= 1'b0;
        end else if (tick) begin
            still_q <= still_q + 16'h0001;
        end
    end
end

// -----------------------------------------------------------------
// parameter access by number
// -----------------------------------------------------------------
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        mode_q <= `RSAP_MODE_RST;
        coarse_q <= `RSAP_COARSE_RST;
        fine_q <= `RSAP_FINE_RST;
        boost_q <= `RSAP_BOOST_RST;
        fw_delay_q <= `RSAP_FW_RST;
        stall_spd_q <= `RSAP_STALL_RST;
        max_dev_q <= `RSAP_DEV_RST;
        par_rdata_q <= 32'h0000_0000;
        par_ack_q <= 1'b0;
    end else begin
        par_ack_q <= par_wr || par_rd;
        if (par_wr) begin
            if (par_num == `RSAP_MODE) mode_q <= par_wdata[7:0];
            else if (par_num == `RSAP_COARSE) coarse_q <= {1'b0, par_wdata[30:0]};
            else if (par_num == `RSAP_FINE) fine_q <= {1'b0, par_wdata[30:0]};
            else if (par_num == `RSAP_BOOST) boost_q <= par_wdata[7:0];
            else if (par_num == `RSAP_FW_DELAY) fw_delay_q <= par_wdata[15:0];
            else if (par_num == `RSAP_STALL_SPEED) stall_spd_q <= {1'b0, par_wdata[30:0]};
            else if (par_num == `RSAP_MAX_DEV) max_dev_q <= {1'b0, par_wdata[30:0]};
        end
        if (par_rd) begin
            if (par_num == `RSAP_MODE) par_rdata_q <= {24'h000000, mode_q};
            else if (par_num == `RSAP_COARSE) par_rdata_q <= coarse_q;
            else if (par_num == `RSAP_FINE) par_rdata_q <= fine_q;
            else if (par_num == `RSAP_SPAN) par_rdata_q <= span_q;
            else if (par_num == `RSAP_PREPOS) par_rdata_q <= prepos_q;
            else if (par_num == `RSAP_BOOST) par_rdata_q <= {24'h000000, boost_q};
            else if (par_num == `RSAP_FW_DELAY) par_rdata_q <= {16'h0000, fw_delay_q};
            // [RULE19] live load value
            else if (par_num == `RSAP_LOAD) par_rdata_q <= {22'h000000, load_value};
            else if (par_num == `RSAP_ERR) par_rdata_q <= {30'h00000000, err_q};
            else if (par_num == `RSAP_STALL_SPEED) par_rdata_q <= stall_spd_q;
            else if (par_num == `RSAP_MAX_DEV) par_rdata_q <= max_dev_q;
            else par_rdata_q <= 32'h0000_0000;
        end
    end
end

endmodule

// ===== hw/rsap_regs.vh
// parameter numbers, reset values and timing for the homing axis block
`ifndef RSAP_REGS_VH
`define RSAP_REGS_VH
`define RSAP_STALL_SPEED 8'hB5
`define RSAP_MODE 8'hC1
`define RSAP_COARSE 8'hC2
`define RSAP_FINE 8'hC3
`define RSAP_SPAN 8'hC4
`define RSAP_PREPOS 8'hC5
`define RSAP_BOOST 8'hC8
`define RSAP_FW_DELAY 8'hCC
`define RSAP_LOAD 8'hCE
`define RSAP_ERR 8'hCF
`define RSAP_MAX_DEV 8'hD4
`define RSAP_MODE_RST 8'h01
`define RSAP_COARSE_RST 32'h0000_0000
`define RSAP_FINE_RST 32'h0000_0000
`define RSAP_BOOST_RST 8'h00
`define RSAP_FW_RST 16'h0000
`define RSAP_STALL_RST 32'h0000_0000
`define RSAP_DEV_RST 32'h0000_0000
`define RSAP_INV_HOME_BIT 7
`define RSAP_RIGHT_BIT 6
`define RSAP_ERR_STALL_BIT 0
`define RSAP_ERR_DEV_BIT 1
`define RSAP_CLK_NS 5
`define RSAP_CLK_HZ 200000000
`define RSAP_TICK_NS 10000000
`endif

// ===== verif/rsap_axis_checker.sv
// concurrent checks on the ports of the homing axis block
`timescale 1ns/10ps
`include "rsap_regs.vh"
module rsap_axis_checker (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] par_num,
    input wire par_wr,
    input wire par_rd,
    input wire [31:0] par_wdata,
    input wire homing_command,
    input wire ext_ramp,
    input wire [7:0] run_current,
    input wire [9:0] load_value,
    input wire [31:0] par_rdata_q,
    input wire par_ack_q,
    input wire [31:0] pos_q,
    input wire step_q,
    input wire homing_busy_q,
    input wire [7:0] coil_current_q,
    input wire power_en_q,
    input wire motor_stop_q
);
    reg [7:0] boost_q;
    reg fw_zero_q;
    // shadow of the boost and freewheel settings seen on the parameter port
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            boost_q <= `RSAP_BOOST_RST;
            fw_zero_q <= 1'b1;
        end else if (par_wr) begin
            if (par_num == `RSAP_BOOST) boost_q <= par_wdata[7:0];
            if (par_num == `RSAP_FW_DELAY) fw_zero_q <= (par_wdata[15:0] == 16'h0000);
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_start;
        homing_command && !motor_stop_q && !homing_busy_q;
    endsequence
    sequence s_done;
        homing_busy_q ##1 (!homing_busy_q && !motor_stop_q);
    endsequence
    busy_start_a: assert property (s_start |=> homing_busy_q)
        else $error("homing did not start");
    home_zero_a: assert property (s_done |-> pos_q == 32'h0)
        else $error("position not zero after homing");
    stop_abort_a: assert property ($rose(motor_stop_q) |-> ##[0:2] !homing_busy_q)
        else $error("homing kept running after stop");
    fw_never_a: assert property (fw_zero_q ##1 fw_zero_q |-> power_en_q)
        else $error("power cut with zero delay");
    boost_pick_a: assert property (power_en_q && !$past(par_wr) && !$past(sys_rst)
        && !$past(sys_rst, 2) && $stable(ext_ramp) && $stable(run_current)
        |-> coil_current_q == ((ext_ramp && boost_q != 8'h00) ? boost_q : run_current))
        else $error("wrong coil current");
    load_read_a: assert property (par_rd && par_num == `RSAP_LOAD
        |=> par_rdata_q == {22'h0, $past(load_value)}) else $error("load readout wrong");
    err_width_a: assert property (par_rd && par_num == `RSAP_ERR
        |=> par_rdata_q[31:2] == 30'h0) else $error("error flags too wide");
    step_pulse_a: assert property (step_q |=> !step_q)
        else $error("step longer than one cycle");
    ack_pulse_a: assert property ((par_wr || par_rd) |=> par_ack_q)
        else $error("no parameter acknowledge");
endmodule
bind rsap_axis rsap_axis_checker i_chk (.clk, .sys_rst, .par_num, .par_wr, .par_rd, .par_wdata,
    .homing_command, .ext_ramp, .run_current, .load_value, .par_rdata_q, .par_ack_q, .pos_q,
    .step_q, .homing_busy_q, .coil_current_q, .power_en_q, .motor_stop_q);

// ===== verif/rsap_motor_model.sv
// stepper shaft model with left and right stop switches and a home switch
`timescale 1ns/10ps
module rsap_motor_model #(
    parameter LEFT_EDGE = -20,
    parameter RIGHT_EDGE = 20,
    parameter HOME_LO = 4,
    parameter HOME_HI = 8
) (
    input wire clk,
    input wire step,
    input wire dir,
    input wire home_inv,
    output wire stop_left,
    output wire stop_right,
    output wire home_sw
);
    integer pos = 0;
    integer since = 0;
    integer gap = 0;
    integer nsteps = 0;
    // one microstep per pulse; gap keeps the cycles between the last two pulses
    always @(posedge clk) begin
        since <= since + 1;
        if (step) begin
            pos <= dir ? pos + 1 : pos - 1;
            gap <= since + 1;
            since <= 0;
            nsteps <= nsteps + 1;
        end
    end
    // switch levels decoded from the shaft position, home may be wired inverted
    assign stop_left = (pos <= LEFT_EDGE);
    assign stop_right = (pos >= RIGHT_EDGE);
    assign home_sw = (pos >= HOME_LO && pos <= HOME_HI) ^ home_inv;
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the homing axis parameter block
`timescale 1ns/10ps
`include "rsap_regs.vh"
module tb_top;
    localparam integer LEFT = -20;
    localparam integer RIGHT = 20;
    localparam integer HOME_LO = 4;
    localparam integer HOME_HI = 8;
    localparam [31:0] COARSE = 32'h0262_5A00;
    localparam [31:0] FINE = 32'h0098_9680;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic par_wr, par_rd, homing_command, motion_cmd, ext_step, ext_dir, ext_ramp, home_inv;
    logic [7:0] par_num, run_current, coil_current_q;
    logic [9:0] load_value;
    logic [31:0] par_wdata, ext_vel, enc_pos, rd, rnd, par_rdata_q, pos_q;
    logic par_ack_q, step_q, dir_q, homing_busy_q, power_en_q, motor_stop_q;
    wire stop_left, stop_right, home_sw;
    integer num_errors = 0;
    integer checks_done = 0;
    rsap_axis #(.TICK_CYC(10)) i_dut (
        .clk, .sys_rst, .par_num, .par_wr, .par_rd, .par_wdata, .homing_command, .motion_cmd,
        .ext_step, .ext_dir, .ext_vel, .ext_ramp, .run_current, .load_value, .enc_pos,
        .stop_left, .stop_right, .home_sw, .par_rdata_q, .par_ack_q, .pos_q, .step_q, .dir_q,
        .homing_busy_q, .coil_current_q, .power_en_q, .motor_stop_q
    );
    rsap_motor_model #(.LEFT_EDGE(LEFT), .RIGHT_EDGE(RIGHT), .HOME_LO(HOME_LO), .HOME_HI(HOME_HI))
        i_mot (.clk, .step(step_q), .dir(dir_q), .home_inv, .stop_left, .stop_right, .home_sw);
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // ------------------------------------------------------------
    // expectations, drivers and compares
    // ------------------------------------------------------------
    function [31:0] lfsr_next(input [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] coil_exp(input r, input [7:0] b, input [7:0] c);
        coil_exp = (r && b != 8'h00) ? b : c;
    endfunction
    function integer home_end(input [7:0] m, input integer s);
        case (m[3:0])
            4'h1, 4'h2: home_end = m[6] ? RIGHT - 1 : LEFT + 1;
            4'h3, 4'h4: home_end = m[6] ? RIGHT : LEFT;
            4'h5: home_end = (s > HOME_HI) ? HOME_HI + 1 : HOME_LO - 1;
            4'h6: home_end = (s < HOME_LO) ? HOME_LO - 1 : HOME_HI + 1;
            4'h7: home_end = HOME_LO - 1;
            default: home_end = HOME_HI + 1;
        endcase
    endfunction
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task chk_val(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chk_bit(input got, input exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    task finish_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one access: strobe for one edge, answer sampled one cycle later
    task par_acc(input wr, input [7:0] n, input [31:0] d);
        par_num = n;
        par_wdata = d;
        par_wr = wr;
        par_rd = !wr;
        tick(1);
        par_wr = 1'b0;
        par_rd = 1'b0;
        chk_bit(par_ack_q, 1'b1);
        rd = par_rdata_q;
        tick(1);
    endtask
    task wr(input [7:0] n, input [31:0] d);
        par_acc(1'b1, n, d);
    endtask
    task rd_chk(input [7:0] n, input [31:0] e);
        par_acc(1'b0, n, 32'h0);
        chk_val(rd, e);
    endtask
    task wait_lvl(input integer sel, input v, input integer lim);
        integer n;
        n = 0;
        while (n < lim && (sel == 0 ? homing_busy_q : sel == 1 ? motor_stop_q :
                sel == 2 ? power_en_q : i_mot.nsteps > 1) !== v)
        begin
            tick(1);
            n = n + 1;
        end
        if (n == lim) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h exp %h", $time, sel, v);
            finish_test;
        end
    endtask
    task run_home(input [7:0] m, input integer s);
        i_mot.pos = s;
        i_mot.nsteps = 0;
        home_inv = m[7];
        tick(4);
        wr(`RSAP_MODE, {24'h0, m});
        homing_command = 1'b1;
        tick(1);
        homing_command = 1'b0;
        chk_bit(homing_busy_q, 1'b1);
        wait_lvl(3, 1'b1, 1000);
        chk_val(i_mot.gap, `RSAP_CLK_HZ / COARSE);
        wait_lvl(0, 1'b0, 20000);
        chk_val(i_mot.gap, `RSAP_CLK_HZ / FINE);
        chk_val(i_mot.pos, home_end(m, s));
        chk_val(pos_q, 32'h0);
        rd_chk(`RSAP_PREPOS, home_end(m, s) - s);
        if (m == 8'h02 || m == 8'h03) rd_chk(`RSAP_SPAN, RIGHT - 1 - home_end(m, s));
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        integer i;
        {par_wr, par_rd, homing_command, motion_cmd, ext_step, ext_dir, ext_ramp} = 7'h00;
        {home_inv, par_num, par_wdata, ext_vel, enc_pos} = 105'h0;
        run_current = 8'h40;
        load_value = 10'h200;
        rnd = 32'h8E02;
        tick(3);
        sys_rst = 1'b0;
        rd_chk(`RSAP_MODE, 32'h1);
        rd_chk(`RSAP_FW_DELAY, 32'h0);
        rd_chk(`RSAP_BOOST, 32'h0);
        rd_chk(8'h10, 32'h0);
        wr(`RSAP_SPAN, 32'h1234_5678);
        rd_chk(`RSAP_SPAN, 32'h0);
        wr(`RSAP_COARSE, 32'hFFFF_FFFF);
        rd_chk(`RSAP_COARSE, 32'h7FFF_FFFF);
        for (i = 0; i < 6; i = i + 1) begin
            rnd = lfsr_next(rnd);
            run_current = rnd[7:0];
            load_value = rnd[17:8] | 10'h001;
            ext_ramp = rnd[18];
            wr(`RSAP_BOOST, rnd[19] ? 32'h0 : {24'h0, rnd[31:24]});
            chk_val({24'h0, coil_current_q},
                {24'h0, coil_exp(ext_ramp, rnd[19] ? 8'h00 : rnd[31:24], run_current)});
            rd_chk(`RSAP_LOAD, {22'h0, load_value});
        end
        ext_ramp = 1'b1;
        wr(`RSAP_BOOST, 32'h0);
        chk_val({24'h0, coil_current_q}, {24'h0, run_current});
        wr(`RSAP_COARSE, COARSE);
        wr(`RSAP_FINE, FINE);
        run_home(8'h01, 0);
        run_home(8'h02, 0);
        run_home(8'h03, 0);
        run_home(8'h04, 0);
        run_home(8'h41, 0);
        run_home(8'h43, 0);
        run_home(8'h05, 15);
        run_home(8'h05, 0);
        run_home(8'h06, 0);
        run_home(8'h06, 15);
        run_home(8'h07, 0);
        run_home(8'h08, 15);
        run_home(8'h87, 0);
        run_home(8'h88, 15);
        wr(`RSAP_STALL_SPEED, 32'h64);
        ext_vel = 32'h32;
        load_value = 10'h000;
        tick(20);
        chk_bit(motor_stop_q, 1'b0);
        ext_vel = 32'h3E8;
        wait_lvl(1, 1'b1, 50);
        load_value = 10'h155;
        rd_chk(`RSAP_ERR, 32'h1);
        rd_chk(`RSAP_ERR, 32'h0);
        motion_cmd = 1'b1;
        tick(1);
        motion_cmd = 1'b0;
        chk_bit(motor_stop_q, 1'b0);
        wr(`RSAP_MAX_DEV, 32'h5);
        {enc_pos, load_value} = {32'hA, 10'h000};
        wait_lvl(1, 1'b1, 50);
        tick(4);
        {enc_pos, load_value} = {32'h0, 10'h155};
        rd_chk(`RSAP_ERR, 32'h3);
        enc_pos = 32'hA;
        tick(4);
        enc_pos = 32'h0;
        tick(4);
        motion_cmd = 1'b1;
        tick(1);
        motion_cmd = 1'b0;
        rd_chk(`RSAP_ERR, 32'h0);
        wr(`RSAP_MAX_DEV, 32'h0);
        enc_pos = 32'hA;
        tick(20);
        chk_bit(motor_stop_q, 1'b0);
        {ext_vel, load_value, homing_command} = 43'h1;
        tick(1);
        homing_command = 1'b0;
        wait_lvl(1, 1'b1, 4);
        wait_lvl(0, 1'b0, 4);
        wr(`RSAP_FW_DELAY, 32'h3);
        ext_vel = 32'h0;
        tick(15);
        chk_bit(power_en_q, 1'b1);
        wait_lvl(2, 1'b0, 40);
        ext_vel = 32'h3E8;
        wait_lvl(2, 1'b1, 10);
        wr(`RSAP_FW_DELAY, 32'h0);
        ext_vel = 32'h0;
        tick(100);
        chk_bit(power_en_q, 1'b1);
        finish_test;
    end
endmodule
